// ===== core/adc_ctrl_regs.vh
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

// Register indices (printed offsets 45h..47h); byte address is index*4
`define REG_IDX_CSR        8'h45
`define REG_IDX_HIGH       8'h46
`define REG_IDX_LOW        8'h47
`define REG_ADDR_CSR       12'h114
`define REG_ADDR_HIGH      12'h118
`define REG_ADDR_LOW       12'h11c
`define REG_ADDR_STATUS    12'h120

// Control/status field positions
`define CSR_DONE_BIT       7
`define CSR_SPEED_BIT      6
`define CSR_ON_BIT         5
`define CSR_SLOW_BIT       4
`define CSR_CH_MSB         3
`define CSR_CH_LSB         0
`define CSR_RESET          8'h00

// Saturation codes
`define RESULT_FULL        10'h3ff
`define RESULT_ZERO        10'h000

// Converter clock selection {slow,speed}
`define DIV_SEL_UNDIV      2'b01
`define DIV_SEL_QUARTER    2'b10
`define DIV_HALF_LAST      2'h1
`define DIV_QUARTER_LAST   2'h3

// Successive approximation length in steps
`define CONV_STEPS         4'ha
// Last converter-clock phase of one step; three clocks cover the sync delay
`define STEP_LAST          2'h2
// First trial code, most significant bit only
`define SAR_MSB            10'h200

`endif

// ===== core/adc_result_fifo.v
`timescale 1ns/10ps
// Small flip-flop FIFO with valid/ready on both sides
module adc_result_fifo #(
	parameter WIDTH = 14,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_rst,
	// Fill side
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	// Drain side
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_r;
	reg [AW-1:0]    rd_ptr_r;
	reg [AW:0]      count_r;
	wire            push;
	wire            pop;

	// Honest flags from the fill count
	assign o_in_ready  = (count_r != DEPTH[AW:0]);
	assign o_out_valid = (count_r != {(AW+1){1'b0}});
	assign o_out_data  = mem_r[rd_ptr_r];
	assign push = i_in_valid & o_in_ready;
	assign pop  = o_out_valid & i_out_ready;

	// Storage written only on accepted pushes
	always @(posedge i_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= i_in_data;
		end
	end

	// Pointers and count
	always @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			if (push & ~pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop & ~push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // adc_result_fifo

// ===== core/adc_conversion_control.v
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "adc_ctrl_regs.vh"
// Notes on behaviour
// - Input above high reference saturates to all ones, no overflow flag.
// - Input below low reference gives a zero result.
// - Setting converter_on starts continuous back-to-back conversions.
// - Each completed conversion sets done flag; loads result unless locked.
// - Reading result_high_byte clears the done flag.
// - Any write to control/status clears the done flag.
// - Changing channel_select aborts, clears done, restarts on new channel.
// - Reading result_low_bits locks both result registers.
// - Lock released by high-byte read or clearing converter_on.
// - Locked result registers take no new conversion data.
// - Slow/speed pick clock: 00,11 half; 01 undivided; 10 quarter.
// - Clearing converter_on stops any conversion in progress.
// - Low nibble channel_select picks one of sixteen inputs.
// - Runs unchanged in wait mode; halt mode disables converter.
// - Control resets to zero; done bit read-only, others read/write.
// - High register shows result bits 9..2, read only.
// - Low register shows bits 1..0, upper six bits zero.
module adc_conversion_control #(
	parameter FIFO_DEPTH = 32,
	parameter FIFO_AW    = 5
) (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst,
	// APB slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output wire        o_pready,
	output reg  [31:0] o_prdata,
	output wire        o_pslverr,
	// Low-power mode requests
	input  wire        i_wait_mode,
	input  wire        i_halt_mode,
	// Analog front end: comparator and range flags
	input  wire        i_cmp_above,
	input  wire        i_over_range,
	input  wire        i_under_range,
	output wire [3:0]  o_channel,
	output wire [9:0]  o_dac_code,
	output wire        o_sample,
	output wire        o_conv_enable,
	// Result stream
	output wire        o_res_valid,
	input  wire        i_res_ready,
	output wire [13:0] o_res_data
);
	// Sequencer states
	localparam ST_IDLE = 2'b00;
	localparam ST_SAMP = 2'b01;
	localparam ST_CONV = 2'b10;
	localparam ST_DONE = 2'b11;

	// Software-visible state
	reg  [7:0]  csr_r;
	reg  [9:0]  result_r;
	reg         lock_r;

	// Sequencer and divider state
	reg  [1:0]  state_r;
	reg  [1:0]  div_r;
	reg  [9:0]  sar_r;
	reg  [3:0]  bit_r;
	reg  [1:0]  ph_r;

	// Two-flop synchroniser stages
	reg         cmp_s1_r;
	reg         cmp_s2_r;
	reg         ovr_s1_r;
	reg         ovr_s2_r;
	reg         und_s1_r;
	reg         und_s2_r;
	reg         halt_s1_r;
	reg         halt_s2_r;

	// Combinational helpers
	reg  [9:0]  final_nxt;
	reg  [9:0]  sar_nxt;
	reg         tick;

	// Bus decode nets
	wire        acc;
	wire        wr;
	wire        rd;
	wire        hit_csr;
	wire        hit_high;
	wire        hit_low;
	wire        hit_status;
	wire        wr_csr;
	wire        rd_high;
	wire        rd_low;

	// Conversion control nets
	wire        conv_on;
	wire        ch_change;
	wire        step;
	wire        finish;
	wire [1:0]  sel;
	wire [9:0]  trial;

	// Stream buffer nets
	wire        fifo_push;
	wire        fifo_in_ready;
	wire [13:0] fifo_data;

	// Comparator pin; two flops before the sequencer reads it
	always @(posedge i_clk) begin
		if (i_rst) begin
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
		end else begin
			cmp_s1_r <= i_cmp_above;
			cmp_s2_r <= cmp_s1_r;
		end
	end

	// Over-range pin synchroniser
	always @(posedge i_clk) begin
		if (i_rst) begin
			ovr_s1_r <= 1'b0;
			ovr_s2_r <= 1'b0;
		end else begin
			ovr_s1_r <= i_over_range;
			ovr_s2_r <= ovr_s1_r;
		end
	end

	// Under-range pin synchroniser
	always @(posedge i_clk) begin
		if (i_rst) begin
			und_s1_r <= 1'b0;
			und_s2_r <= 1'b0;
		end else begin
			und_s1_r <= i_under_range;
			und_s2_r <= und_s1_r;
		end
	end

	// Halt request synchroniser
	always @(posedge i_clk) begin
		if (i_rst) begin
			halt_s1_r <= 1'b0;
			halt_s2_r <= 1'b0;
		end else begin
			halt_s1_r <= i_halt_mode;
			halt_s2_r <= halt_s1_r;
		end
	end

	// Access qualifiers; zero wait states
	assign acc      = i_psel & i_penable;
	assign wr       = acc & i_pwrite;
	assign rd       = acc & ~i_pwrite;
	assign o_pready = 1'b1;

	// Register hits by byte address
	assign hit_csr    = (i_paddr == `REG_ADDR_CSR);
	assign hit_high   = (i_paddr == `REG_ADDR_HIGH);
	assign hit_low    = (i_paddr == `REG_ADDR_LOW);
	assign hit_status = (i_paddr == `REG_ADDR_STATUS);

	// Side-effect strobes
	assign wr_csr  = wr & hit_csr;
	assign rd_high = rd & hit_high;
	assign rd_low  = rd & hit_low;

	// Unmapped addresses answer with an error
	assign o_pslverr = acc & ~(hit_csr | hit_high | hit_low | hit_status);

	// Wait mode is ignored on purpose; halt stops the converter
	assign conv_on   = csr_r[`CSR_ON_BIT] & ~halt_s2_r;
	assign ch_change = wr_csr & (i_pwdata[`CSR_CH_MSB:`CSR_CH_LSB] !=
		csr_r[`CSR_CH_MSB:`CSR_CH_LSB]);
	assign sel       = {csr_r[`CSR_SLOW_BIT], csr_r[`CSR_SPEED_BIT]};

	// One step per three converter clocks: the synchronised
	// comparator lags the trial code by two clock edges
	assign trial  = `SAR_MSB >> bit_r;
	assign step   = (state_r == ST_CONV) & tick &
		(ph_r == `STEP_LAST);
	assign finish = step &
		(bit_r == `CONV_STEPS - 4'h1);

	// Converter clock enable from the divider selection
	always @* begin
		case (sel)
		`DIV_SEL_UNDIV:   tick = 1'b1;
		`DIV_SEL_QUARTER: tick = (div_r == `DIV_QUARTER_LAST);
		default:          tick = (div_r[0] == `DIV_HALF_LAST);
		endcase
	end

	// Range flags override the approximation result
	always @* begin
		if (ovr_s2_r) begin
			final_nxt = `RESULT_FULL;
		end else if (und_s2_r) begin
			final_nxt = `RESULT_ZERO;
		end else begin
			final_nxt = {sar_r[9:1], cmp_s2_r};
		end
	end

	// Keep or drop the trial bit, then try the next lower bit
	always @* begin
		if (cmp_s2_r) begin
			sar_nxt = sar_r | (trial >> 1);
		end else begin
			sar_nxt = (sar_r & ~trial) | (trial >> 1);
		end
	end

	// Divider free-runs while the converter is on
	always @(posedge i_clk) begin
		if (i_rst || !conv_on) begin
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end

	// Conversion sequencer; abort on off, halt or new channel
	always @(posedge i_clk) begin
		if (i_rst || !conv_on || ch_change) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
			ST_IDLE: begin
				state_r <= ST_SAMP;
			end
			ST_SAMP: begin
				if (tick) begin
					state_r <= ST_CONV;
				end
			end
			ST_CONV: begin
				if (finish) begin
					state_r <= ST_DONE;
				end
			end
			ST_DONE: begin
				state_r <= ST_SAMP;
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// Trial code register
	always @(posedge i_clk) begin
		if (i_rst || !conv_on || ch_change) begin
			sar_r <= 10'h000;
		end else if ((state_r == ST_SAMP) && tick) begin
			sar_r <= `SAR_MSB;
		end else if (step) begin
			sar_r <= sar_nxt;
		end
	end

	// Bit index under trial
	always @(posedge i_clk) begin
		if (i_rst || !conv_on || ch_change) begin
			bit_r <= 4'h0;
		end else if ((state_r == ST_SAMP) && tick) begin
			bit_r <= 4'h0;
		end else if (step) begin
			bit_r <= bit_r + 4'h1;
		end
	end

	// Converter-clock phase within one step
	always @(posedge i_clk) begin
		if (i_rst || !conv_on || ch_change) begin
			ph_r <= 2'h0;
		end else if ((state_r != ST_CONV) || step) begin
			ph_r <= 2'h0;
		end else if (tick) begin
			ph_r <= ph_r + 2'h1;
		end
	end

	// Control/status register; done bit set wins over clear
	always @(posedge i_clk) begin
		if (i_rst) begin
			csr_r <= `CSR_RESET;
		end else begin
			if (wr_csr) begin
				csr_r[6:0] <= i_pwdata[6:0];
			end
			if (finish && !ch_change) begin
				csr_r[`CSR_DONE_BIT] <= 1'b1;
			end else if (wr_csr || rd_high) begin
				csr_r[`CSR_DONE_BIT] <= 1'b0;
			end
		end
	end

	// Result; a locked pair is held until the high byte is read or converter_on is cleared
	always @(posedge i_clk) begin
		if (i_rst) begin
			result_r <= 10'h000;
		end else begin
			if (finish && !lock_r && !ch_change) begin
				result_r <= final_nxt;
			end
		end
	end

	// Lock; release wins over a low read in the same cycle
	always @(posedge i_clk) begin
		if (i_rst) begin
			lock_r <= 1'b0;
		end else if (rd_high || !csr_r[`CSR_ON_BIT]) begin
			lock_r <= 1'b0;
		end else if (rd_low) begin
			lock_r <= 1'b1;
		end
	end

	// Read mux; reading has side effects handled above
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_prdata <= 32'h0000_0000;
		end else if (rd) begin
			case (i_paddr)
			`REG_ADDR_CSR:    o_prdata <= {24'h00_0000, csr_r};
			`REG_ADDR_HIGH:   o_prdata <= {24'h00_0000, result_r[9:2]};
			`REG_ADDR_LOW:    o_prdata <= {30'h0, result_r[1:0]};
			`REG_ADDR_STATUS: o_prdata <= {29'h0, ~fifo_in_ready,
				o_res_valid, lock_r};
			default:          o_prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Every conversion is also offered to the stream buffer, tagged by channel
	assign fifo_push = finish & ~ch_change;
	assign fifo_data = {csr_r[`CSR_CH_MSB:`CSR_CH_LSB], final_nxt};

	// Stream buffer; when full only the stream loses words
	adc_result_fifo #(
		.WIDTH (14),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_in_valid  (fifo_push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fifo_data),
		.o_out_valid (o_res_valid),
		.i_out_ready (i_res_ready),
		.o_out_data  (o_res_data)
	);

	// Analog front end drive
	assign o_channel     = csr_r[`CSR_CH_MSB:`CSR_CH_LSB];
	assign o_dac_code    = sar_r;

	// Front end status strobes
	assign o_sample      = (state_r == ST_SAMP);
	assign o_conv_enable = conv_on;
endmodule // adc_conversion_control

// ===== testbench/adc_ctrl_props.sv
`timescale 1ns/10ps
`include "adc_ctrl_regs.vh"
module adc_ctrl_props (
	input wire logic        i_clk, i_rst, i_psel, i_penable,
	input wire logic        i_pwrite, i_halt_mode, o_sample,
	input wire logic        o_conv_enable,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata, o_prdata,
	input wire logic [3:0]  o_channel
);
	logic on_r;
	// Read and write decodes seen at the access edge
	wire rdq = i_psel && i_penable && !i_pwrite;
	wire wr = i_psel && i_penable && i_pwrite && i_paddr == `REG_ADDR_CSR;
	wire go = wr && i_pwdata[5];
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Shadow of the on bit; only software writes it
	always @(posedge i_clk)
		on_r <= i_rst ? 1'b0 : (wr ? i_pwdata[5] : on_r);
	property p_chan; wr |=> o_channel == $past(i_pwdata[3:0]); endproperty
	a_chan: assert property (p_chan) else $error("chan");
	property p_off; wr && !i_pwdata[5] |=> !o_conv_enable; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_start;
		!i_halt_mode [*3] ##0 (go && !on_r) |-> ##[1:8] o_sample;
	endproperty
	a_start: assert property (p_start) else $error("start");
	property p_restart;
		!i_halt_mode [*3] ##0 (go && on_r && i_pwdata[3:0] != o_channel)
			|-> ##[1:8] o_sample;
	endproperty
	a_restart: assert property (p_restart) else $error("restart");
	// Sampling recurs without software, unless disabled
	property p_cont;
		o_conv_enable && $fell(o_sample)
			|-> ##[1:160] (o_sample || !o_conv_enable);
	endproperty
	a_cont: assert property (p_cont) else $error("cont");
	property p_halt; i_halt_mode [*3] |-> !o_conv_enable; endproperty
	a_halt: assert property (p_halt) else $error("halt");
	property p_low;
		rdq && i_paddr == `REG_ADDR_LOW |=> o_prdata[31:2] == 0;
	endproperty
	a_low: assert property (p_low) else $error("low");
	property p_high;
		rdq && i_paddr == `REG_ADDR_HIGH |=> o_prdata[31:8] == 0;
	endproperty
	a_high: assert property (p_high) else $error("high");
	c_go: cover property (go && !on_r);
	c_lock: cover property (rdq && i_paddr == `REG_ADDR_LOW);
	c_halt: cover property (i_halt_mode [*3]);
endmodule // adc_ctrl_props
bind adc_conversion_control adc_ctrl_props adc_ctrl_props_inst (
	.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_halt_mode(i_halt_mode), .o_sample(o_sample),
	.o_conv_enable(o_conv_enable), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_channel(o_channel));

// ===== testbench/afe_model.sv
`timescale 1ns/10ps
module afe_model (
	input wire logic [3:0] i_channel,
	input wire logic [9:0] i_dac_code,
	input wire logic [9:0] i_level [16],
	output logic           o_cmp_above
);
	// Input sits half a step above its level, so no tie
	assign o_cmp_above = i_dac_code <= i_level[i_channel];
endmodule // afe_model

// ===== testbench/adc_conversion_control_bench.sv
`timescale 1ns/10ps
`include "adc_ctrl_regs.vh"
module adc_conversion_control_bench;
	logic i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic i_wait_mode = 0, i_halt_mode = 0, i_over_range = 0;
	logic i_under_range = 0, i_res_ready = 0, i_cmp_above, o_pready;
	logic o_pslverr, o_sample, o_conv_enable, o_res_valid, err;
	logic sm = 0, rr = 0;
	logic [11:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0, o_prdata, rdat, e, q[$];
	logic [3:0]  o_channel;
	logic [9:0]  o_dac_code, v, lvl [16];
	logic [13:0] o_res_data;
	int mismatches = 0, compares = 0, n, k, cyc = 0, t[4];
	event rd_ev;
	adc_conversion_control adc_conversion_control_inst (
		.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
		.o_pslverr(o_pslverr), .i_wait_mode(i_wait_mode),
		.i_halt_mode(i_halt_mode), .i_cmp_above(i_cmp_above),
		.i_over_range(i_over_range), .i_under_range(i_under_range),
		.o_channel(o_channel), .o_dac_code(o_dac_code),
		.o_sample(o_sample), .o_conv_enable(o_conv_enable),
		.o_res_valid(o_res_valid), .i_res_ready(i_res_ready),
		.o_res_data(o_res_data));
	afe_model afe_model_inst (.i_channel(o_channel),
		.i_dac_code(o_dac_code), .i_level(lvl), .o_cmp_above(i_cmp_above));
	// Clock, cycle count and random drain
	initial forever #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) cyc <= cyc + 1;
	always @(posedge i_clk) if (rr) i_res_ready <= 1'($urandom);
	task automatic chk(input string nm, input logic [31:0] s, x);
		compares++;
		if (s !== x) begin
			mismatches++;
			$display("[FAIL] %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One APB transfer, held until pready at an edge
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge i_clk);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1 && n < 50);
		err = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
		if (n == 50) begin
			mismatches++;
			conclude;
		end
		#1 rdat = o_prdata;
	endtask
	task automatic wr(input logic [31:0] d);
		apb(1, `REG_ADDR_CSR, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		q.push_back(x);
		apb(0, a, 0);
		->rd_ev;
	endtask
	// Poll the done flag, bounded
	task automatic wait_done;
		k = 0;
		do begin
			apb(0, `REG_ADDR_CSR, 0);
			k++;
		end while (rdat[7] !== 1 && k < 100);
		if (k == 100) begin
			mismatches++;
			conclude;
		end
	endtask
	// Observers: read data and stream words against notes
	always @(rd_ev) chk("rdata", rdat, q.pop_front());
	always @(posedge i_clk)
		if (sm && o_res_valid === 1 && i_res_ready)
			chk("stream", o_res_data, {4'h5, lvl[5]});
	initial begin
		void'($urandom(32'hf8b5b80e));
		foreach (lvl[j]) lvl[j] = 10'($urandom);
		repeat (20) @(posedge i_clk);
		i_rst <= 0;
		rd(`REG_ADDR_CSR, 0);
		rd(`REG_ADDR_LOW, 0);
		rd(`REG_ADDR_HIGH, 0);
		rd(12'h200, 0);
		chk("slverr", err, 1);
		// Every clock code, each on a new channel
		for (int i = 0; i < 4; i++) begin
			i_wait_mode <= i[1];
			e = {24'h0, 1'b0, i[0], 1'b1, i[1], 4'(i + 1)};
			t[i] = cyc;
			wr(e | 32'h80);
			rd(`REG_ADDR_CSR, e);
			wait_done;
			t[i] = cyc - t[i];
			rd(`REG_ADDR_LOW, lvl[i + 1][1:0]);
			rd(`REG_ADDR_HIGH, lvl[i + 1][9:2]);
		end
		chk("div", t[1] < t[0] && t[0] < t[2], 1);
		chk("div", t[3] + 4 > t[0] && t[3] < t[0] + 4, 1);
		// Low read locks the pair across new conversions
		v = lvl[4];
		wait_done;
		rd(`REG_ADDR_LOW, v[1:0]);
		lvl[4] = ~v;
		repeat (100) @(posedge i_clk);
		rd(`REG_ADDR_HIGH, v[9:2]);
		wait_done;
		rd(`REG_ADDR_HIGH, lvl[4][9:2]);
		rd(`REG_ADDR_CSR, e);
		for (int j = 0; j < 2; j++) begin
			{i_over_range, i_under_range} <= j ? 2'b01 : 2'b10;
			repeat (5) @(posedge i_clk);
			e = e ^ 32'h8;
			wr(e);
			wait_done;
			rd(`REG_ADDR_LOW, j ? 0 : 3);
			rd(`REG_ADDR_HIGH, j ? 0 : 8'hff);
		end
		{i_over_range, i_under_range} <= 0;
		i_halt_mode <= 1;
		repeat (10) @(posedge i_clk);
		chk("enable", o_conv_enable, 0);
		i_halt_mode <= 0;
		// Fill the buffer with the drain stalled, then empty it
		i_res_ready <= 1;
		wr(32'h25);
		repeat (60) @(posedge i_clk);
		i_res_ready <= 0;
		sm = 1;
		repeat (2300) @(posedge i_clk);
		rd(`REG_ADDR_STATUS, 6);
		wr(32'h05);
		rr = 1;
		repeat (300) @(posedge i_clk);
		rr = 0;
		rd(`REG_ADDR_STATUS, 0);
		rd(`REG_ADDR_CSR, 5);
		conclude;
	end
endmodule // adc_conversion_control_bench
